/* src/uhc_port_ctrl.sv */
// Hub controller: global state, hub power status, port commands, APB slave.
// Assumes APB from firmware and pulses from the USB engine on the core clock.
//
// Local design decision: the APB register port.
`default_nettype none
module uhc_port_ctrl
  import uhc_pkg::*;
#(
  parameter int RESET_CYC = UHC_RESET_CYC,
  parameter int RESUME_CYC = UHC_RESUME_CYC,
  parameter int EOP_CYC = UHC_EOP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [UHC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_suspended,
  input wire logic upstream_resume,
  input wire logic downstream_resume_done,
  input wire logic bus_reset,
  input wire logic set_config_zero,
  input wire logic eof2,
  input wire logic ep1_in_token,
  output logic ep1_ack,
  output logic ep1_nak,
  output logic [7:0] ep1_report,
  output logic address_valid,
  output logic hub_configured,
  output logic func_reset,
  output logic func_suspended,
  output logic [UHC_NPORT-1:0] port_enabled,
  output logic [UHC_NPORT-1:0] port_suspended,
  output logic [UHC_NPORT-1:0] port_resetting,
  output logic [UHC_NPORT-1:0] port_drive_k,
  output logic [UHC_NPORT-1:0] port_drive_se0,
  output logic [UHC_NPORT-1:0] port_forward
);
  logic [7:0] glb_ff;
  logic [7:0] pwr_ff;
  logic [7:0] cmd_ff;
  logic go_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [7:0] rd_val;
  logic rd_hit;
  logic wr;
  logic wlane;
  uhc_reg_t wsel;
  uhc_reg_t rsel;
  logic [2:0] cmd_code;
  logic [2:0] cmd_sel;
  logic [7:0] pst [UHC_NPORT];
  logic [7:0] pch_ff [UHC_NPORT];
  logic [UHC_NPORT-1:0] rst_done;
  logic [UHC_NPORT-1:0] res_done;
  logic [7:0] bitmap;
  logic [UHC_NPORT-1:0] port_chg;

  function automatic uhc_reg_t reg_of(input logic [UHC_AW-1:0] a);
    logic [UHC_IW-1:0] idx;
    idx = a[UHC_AW-1:2];
    if (a[1:0] != 2'h0) begin
      reg_of = UHC_R_NONE;
    end else if (idx == UHC_IDX_GLOBAL) begin
      reg_of = UHC_R_GLOBAL;
    end else if (idx == UHC_IDX_POWER) begin
      reg_of = UHC_R_POWER;
    end else if (idx == UHC_IDX_CMD) begin
      reg_of = UHC_R_CMD;
    end else if (idx == UHC_IDX_PST2) begin
      reg_of = UHC_R_PST2;
    end else if (idx == UHC_IDX_PST3) begin
      reg_of = UHC_R_PST3;
    end else if (idx == UHC_IDX_PCH2) begin
      reg_of = UHC_R_PCH2;
    end else if (idx == UHC_IDX_PCH3) begin
      reg_of = UHC_R_PCH3;
    end else begin
      reg_of = UHC_R_NONE;
    end
  endfunction

  assign rsel = reg_of(paddr);
  assign wsel = rsel;
  assign wr = psel & penable & pready_ff & pwrite;
  assign wlane = pstrb[0];
  assign cmd_code = cmd_ff[UHC_CMD_LSB +: 3];
  assign cmd_sel = cmd_ff[UHC_SEL_LSB +: 3];

  // Read data is sampled in the setup cycle, so zero-wait-state answers
  always_comb begin
    rd_val = UHC_RESET_VAL;
    rd_hit = 1'b1;
    case (rsel)
      UHC_R_GLOBAL: rd_val = glb_ff;
      UHC_R_POWER: rd_val = pwr_ff & UHC_PWR_MASK;
      UHC_R_CMD: rd_val = cmd_ff & UHC_CMD_MASK;
      UHC_R_PST2: rd_val = pst[0];
      UHC_R_PST3: rd_val = pst[1];
      UHC_R_PCH2: rd_val = pch_ff[0];
      UHC_R_PCH3: rd_val = pch_ff[1];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (ce) begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~rd_hit;
      if (psel & ~penable & ~pwrite) begin
        prdata_ff <= {24'h000000, rd_val};
      end
    end
  end

  // Global state: hardware flags plus firmware bits with hardware clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glb_ff <= UHC_RESET_VAL;
    end else if (ce) begin
      if (wr & wlane & (wsel == UHC_R_GLOBAL)) begin
        glb_ff[UHC_G_WAKE] <= pwdata[UHC_G_WAKE];
        glb_ff[UHC_G_CONF] <= pwdata[UHC_G_CONF];
        glb_ff[UHC_G_ADDR] <= pwdata[UHC_G_ADDR];
      end
      if (set_config_zero | bus_reset) begin
        glb_ff[UHC_G_CONF] <= 1'b0;
      end
      if (bus_reset) begin
        glb_ff[UHC_G_ADDR] <= 1'b0;
        glb_ff[UHC_G_WAKE] <= 1'b0;
      end
      glb_ff[UHC_G_SUSP] <= usb_suspended;
      if (upstream_resume) begin
        glb_ff[UHC_G_RES] <= 1'b1;
      end else if (downstream_resume_done) begin
        glb_ff[UHC_G_RES] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ff <= UHC_RESET_VAL;
    end else if (ce) begin
      if (wr & wlane & (wsel == UHC_R_POWER)) begin
        pwr_ff <= pwdata[7:0] & UHC_PWR_MASK;
      end
    end
  end

  // A write to the command register launches the command once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= UHC_RESET_VAL;
      go_ff <= 1'b0;
    end else if (ce) begin
      go_ff <= wr & wlane & (wsel == UHC_R_CMD);
      if (wr & wlane & (wsel == UHC_R_CMD)) begin
        cmd_ff <= pwdata[7:0] & UHC_CMD_MASK;
      end
    end
  end

  // Embedded function port: hardware only stops answering and pulses reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reset <= 1'b0;
      func_suspended <= 1'b0;
    end else if (ce) begin
      func_reset <= go_ff & (cmd_sel == UHC_SEL_FUNC) & (cmd_code == UHC_PC_RESET);
      if (go_ff & (cmd_sel == UHC_SEL_FUNC)) begin
        if (cmd_code == UHC_PC_SUSPEND) begin
          func_suspended <= 1'b1;
        end else if ((cmd_code == UHC_PC_RESUME) | (cmd_code == UHC_PC_RESET)) begin
          func_suspended <= 1'b0;
        end
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < UHC_NPORT; gi++) begin : g_port
      logic hit;
      assign hit = go_ff & (cmd_sel == (UHC_SEL_FIRST + 3'(gi)));
      uhc_port_seq #(
        .RESET_CYC(RESET_CYC),
        .RESUME_CYC(RESUME_CYC),
        .EOP_CYC(EOP_CYC)
      ) u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .go(hit),
        .cmd(cmd_code),
        .eof2(eof2),
        .en_ff(port_enabled[gi]),
        .susp_ff(port_suspended[gi]),
        .rst_ff(port_resetting[gi]),
        .k_ff(port_drive_k[gi]),
        .se0_ff(port_drive_se0[gi]),
        .fwd_ff(port_forward[gi]),
        .rst_done_ff(rst_done[gi]),
        .res_done_ff(res_done[gi])
      );
      always_comb begin
        pst[gi] = UHC_RESET_VAL;
        pst[gi][UHC_PS_EN] = port_enabled[gi];
        pst[gi][UHC_PS_SUSP] = port_suspended[gi];
        pst[gi][UHC_PS_RST] = port_resetting[gi];
      end
      // Write one to clear; a hardware set in the same cycle wins
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pch_ff[gi] <= UHC_RESET_VAL;
        end else if (ce) begin
          if (wr & wlane & (wsel == ((gi == 0) ? UHC_R_PCH2 : UHC_R_PCH3))) begin
            pch_ff[gi][UHC_PC_RST] <= rst_done[gi] | (pch_ff[gi][UHC_PC_RST] & ~pwdata[UHC_PC_RST]);
            pch_ff[gi][UHC_PC_SUSP] <= res_done[gi] | (pch_ff[gi][UHC_PC_SUSP] & ~pwdata[UHC_PC_SUSP]);
          end else begin
            pch_ff[gi][UHC_PC_RST] <= pch_ff[gi][UHC_PC_RST] | rst_done[gi];
            pch_ff[gi][UHC_PC_SUSP] <= pch_ff[gi][UHC_PC_SUSP] | res_done[gi];
          end
        end
      end
      assign port_chg[gi] = |pch_ff[gi];
    end
  endgenerate

  always_comb begin
    bitmap = UHC_RESET_VAL;
    bitmap[UHC_BM_HUB] = pwr_ff[UHC_PWR_HUB_OC] | pwr_ff[UHC_PWR_OVC];
    bitmap[UHC_BM_FIRST +: UHC_NPORT] = port_chg;
  end

  uhc_ep1_report u_ep1 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .change(bitmap),
    .in_token(ep1_in_token),
    .ack_ff(ep1_ack),
    .nak_ff(ep1_nak),
    .report_ff(ep1_report)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign address_valid = glb_ff[UHC_G_ADDR];
  assign hub_configured = glb_ff[UHC_G_CONF];
endmodule
`default_nettype wire

/* src/uhc_pkg.sv */
// Constants, register map and types of the hub port control block.
// Assumes a single core clock; all users import the whole package.
// Behaviour
// - Interrupt endpoint one served fully in hardware
// - No change since last report gives NAK
// - Suspended flag follows USB suspend, read-only
// - Resume flag set upstream, cleared after downstream
// - Configured cleared by reset or config zero
// - Address valid enables new address next transaction
// - Power status holds four bits, rest zero
// - Bitmap bit zero is overcurrent or change
// - Command field bits six to four decoded
// - Disable command disables addressed external port
// - Enable command enables addressed external port
// - Reset command signals reset, resets function
// - Suspend command idles port, stops forwarding
// - Resume command signals resume then enables
// - Bits two to zero select the port
// - Command register bits seven, three read zero
// - Resume drives K, then EOP, then enables
// - At EOF2 after reset: enabled, reset done
`default_nettype none
package uhc_pkg;
  localparam int UHC_AW = 16;
  localparam int UHC_IW = 14;
  localparam int UHC_CW = 32;
  localparam int UHC_NPORT = 2;
  // Register indices; byte address is four times the index
  localparam logic [UHC_IW-1:0] UHC_IDX_GLOBAL = 14'h1ffb;
  localparam logic [UHC_IW-1:0] UHC_IDX_POWER = 14'h1ffc;
  localparam logic [UHC_IW-1:0] UHC_IDX_CMD = 14'h1ffd;
  localparam logic [UHC_IW-1:0] UHC_IDX_PST2 = 14'h1fb9;
  localparam logic [UHC_IW-1:0] UHC_IDX_PST3 = 14'h1fba;
  localparam logic [UHC_IW-1:0] UHC_IDX_PCH2 = 14'h1fb1;
  localparam logic [UHC_IW-1:0] UHC_IDX_PCH3 = 14'h1fb2;
  // Global state fields
  localparam int UHC_G_ADDR = 0;
  localparam int UHC_G_CONF = 1;
  localparam int UHC_G_WAKE = 2;
  localparam int UHC_G_RES = 3;
  localparam int UHC_G_SUSP = 4;
  localparam logic [7:0] UHC_G_RW_MASK = 8'h07;
  localparam logic [7:0] UHC_PWR_MASK = 8'h0f;
  localparam int UHC_PWR_HUB_OC = 1;
  localparam int UHC_PWR_OVC = 3;
  // Port command register fields
  localparam int UHC_CMD_LSB = 4;
  localparam int UHC_SEL_LSB = 0;
  localparam logic [7:0] UHC_CMD_MASK = 8'h77;
  localparam logic [2:0] UHC_SEL_FUNC = 3'h1;
  localparam logic [2:0] UHC_SEL_FIRST = 3'h2;
  // Port status and change fields
  localparam int UHC_PS_EN = 1;
  localparam int UHC_PS_SUSP = 2;
  localparam int UHC_PS_RST = 4;
  localparam int UHC_PC_SUSP = 2;
  localparam int UHC_PC_RST = 4;
  localparam int UHC_BM_HUB = 0;
  localparam int UHC_BM_FIRST = 2;
  localparam logic [7:0] UHC_RESET_VAL = 8'h00;
  // Timing
  localparam int UHC_CLK_NS = 10;
  localparam int UHC_RESUME_MS = 20;
  localparam int UHC_RESET_MS = 10;
  localparam int UHC_EOP_NS = 1334;
  localparam int UHC_RESUME_CYC = (UHC_RESUME_MS * 1000000 + UHC_CLK_NS - 1) / UHC_CLK_NS;
  localparam int UHC_RESET_CYC = (UHC_RESET_MS * 1000000 + UHC_CLK_NS - 1) / UHC_CLK_NS;
  localparam int UHC_EOP_CYC = (UHC_EOP_NS + UHC_CLK_NS - 1) / UHC_CLK_NS;
  typedef enum logic [2:0] {
    UHC_PC_DISABLE = 3'h0,
    UHC_PC_ENABLE = 3'h1,
    UHC_PC_RESET = 3'h2,
    UHC_PC_SUSPEND = 3'h3,
    UHC_PC_RESUME = 3'h4
  } uhc_cmd_t;
  typedef enum {UHC_R_NONE, UHC_R_GLOBAL, UHC_R_POWER, UHC_R_CMD,
    UHC_R_PST2, UHC_R_PST3, UHC_R_PCH2, UHC_R_PCH3} uhc_reg_t;
endpackage
`default_nettype wire

/* src/uhc_port_seq.sv */
// Per-port state sequencer for one external downstream port.
// Assumes one-cycle command pulses and an EOF2 pulse from the frame timer.
`default_nettype none
module uhc_port_seq
  import uhc_pkg::*;
#(
  parameter int RESET_CYC = UHC_RESET_CYC,
  parameter int RESUME_CYC = UHC_RESUME_CYC,
  parameter int EOP_CYC = UHC_EOP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic go,
  input wire logic [2:0] cmd,
  input wire logic eof2,
  output logic en_ff,
  output logic susp_ff,
  output logic rst_ff,
  output logic k_ff,
  output logic se0_ff,
  output logic fwd_ff,
  output logic rst_done_ff,
  output logic res_done_ff
);
  typedef enum {UHC_SQ_IDLE, UHC_SQ_RST, UHC_SQ_RST_EOF, UHC_SQ_K, UHC_SQ_EOP} uhc_sq_t;
  uhc_sq_t st_ff;
  logic [UHC_CW-1:0] cnt_ff;
  logic cnt_zero;

  assign cnt_zero = (cnt_ff == '0);

  // Commands arriving mid-sequence are dropped; firmware waits for the change flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= UHC_SQ_IDLE;
      cnt_ff <= '0;
      en_ff <= 1'b0;
      susp_ff <= 1'b0;
      rst_ff <= 1'b0;
      k_ff <= 1'b0;
      se0_ff <= 1'b0;
      rst_done_ff <= 1'b0;
      res_done_ff <= 1'b0;
    end else if (ce) begin
      rst_done_ff <= 1'b0;
      res_done_ff <= 1'b0;
      if (!cnt_zero) begin
        cnt_ff <= cnt_ff - UHC_CW'(1);
      end
      case (st_ff)
        UHC_SQ_IDLE: begin
          if (go) begin
            case (cmd)
              UHC_PC_DISABLE: begin
                en_ff <= 1'b0;
                susp_ff <= 1'b0;
              end
              UHC_PC_ENABLE: begin
                en_ff <= 1'b1;
                susp_ff <= 1'b0;
              end
              UHC_PC_RESET: begin
                rst_ff <= 1'b1;
                se0_ff <= 1'b1;
                cnt_ff <= UHC_CW'(RESET_CYC - 1);
                st_ff <= UHC_SQ_RST;
              end
              UHC_PC_SUSPEND: begin
                if (en_ff) begin
                  susp_ff <= 1'b1;
                end
              end
              UHC_PC_RESUME: begin
                if (susp_ff) begin
                  k_ff <= 1'b1;
                  cnt_ff <= UHC_CW'(RESUME_CYC - 1);
                  st_ff <= UHC_SQ_K;
                end
              end
              default: begin
                st_ff <= UHC_SQ_IDLE;
              end
            endcase
          end
        end
        UHC_SQ_RST: begin
          if (cnt_zero) begin
            se0_ff <= 1'b0;
            st_ff <= UHC_SQ_RST_EOF;
          end
        end
        UHC_SQ_RST_EOF: begin
          if (eof2) begin
            en_ff <= 1'b1;
            susp_ff <= 1'b0;
            rst_ff <= 1'b0;
            rst_done_ff <= 1'b1;
            st_ff <= UHC_SQ_IDLE;
          end
        end
        UHC_SQ_K: begin
          if (cnt_zero) begin
            k_ff <= 1'b0;
            se0_ff <= 1'b1;
            cnt_ff <= UHC_CW'(EOP_CYC - 1);
            st_ff <= UHC_SQ_EOP;
          end
        end
        UHC_SQ_EOP: begin
          if (cnt_zero) begin
            se0_ff <= 1'b0;
            susp_ff <= 1'b0;
            en_ff <= 1'b1;
            res_done_ff <= 1'b1;
            st_ff <= UHC_SQ_IDLE;
          end
        end
        default: begin
          st_ff <= UHC_SQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_ff <= 1'b0;
    end else if (ce) begin
      fwd_ff <= en_ff & ~susp_ff & ~rst_ff;
    end
  end
endmodule
`default_nettype wire

/* src/uhc_ep1_report.sv */
// Hub interrupt endpoint one: change bitmap report with NAK when nothing new.
// Assumes one-cycle IN token pulses already matched to this endpoint.
`default_nettype none
module uhc_ep1_report
  import uhc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] change,
  input wire logic in_token,
  output logic ack_ff,
  output logic nak_ff,
  output logic [7:0] report_ff
);
  logic [7:0] prev_ff;
  logic pend_ff;
  logic fresh;

  assign fresh = |(change & ~prev_ff);

  // A change in the same cycle as a token is sent now, never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= UHC_RESET_VAL;
      pend_ff <= 1'b0;
      ack_ff <= 1'b0;
      nak_ff <= 1'b0;
      report_ff <= UHC_RESET_VAL;
    end else if (ce) begin
      prev_ff <= change;
      ack_ff <= in_token & (pend_ff | fresh);
      nak_ff <= in_token & ~(pend_ff | fresh);
      if (in_token & (pend_ff | fresh)) begin
        report_ff <= change;
        pend_ff <= 1'b0;
      end else if (fresh) begin
        pend_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/uhc_usb_side_model.sv */
// Upstream USB engine stand-in: frame marker and hub endpoint one IN tokens.
// Assumes the bench requests tokens with one-cycle pulses on tok_go.
`default_nettype none
module uhc_usb_side_model #(
  parameter int EOF_PER = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tok_go,
  output logic eof2,
  output logic ep1_in_token
);
  int cnt_ff;
  // Frame timer runs free, as SOFs keep coming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 0;
      eof2 <= 1'h0;
    end else begin
      cnt_ff <= (cnt_ff == EOF_PER - 1) ? 0 : cnt_ff + 1;
      eof2 <= (cnt_ff == EOF_PER - 1);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep1_in_token <= 1'h0;
    end else begin
      ep1_in_token <= tok_go;
    end
  end
endmodule
`default_nettype wire

/* verification/uhc_port_ctrl_asserts.sv */
// Port-level assertions for the hub port controller.
// Assumes ce held high; bound to uhc_port_ctrl below.
`default_nettype none
module uhc_port_ctrl_asserts
  import uhc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_reset,
  input wire logic set_config_zero,
  input wire logic eof2,
  input wire logic ep1_in_token,
  input wire logic ep1_ack,
  input wire logic ep1_nak,
  input wire logic address_valid,
  input wire logic hub_configured,
  input wire logic [UHC_NPORT-1:0] port_enabled,
  input wire logic [UHC_NPORT-1:0] port_resetting,
  input wire logic [UHC_NPORT-1:0] port_drive_k,
  input wire logic [UHC_NPORT-1:0] port_drive_se0
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready not a single cycle after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access cycle");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  property p_ep1; ep1_in_token |=> ep1_ack != ep1_nak; endproperty
  a_ep1: assert property (p_ep1) else $error("token not answered by ack or nak");
  property p_ep1_src; ep1_ack || ep1_nak |-> $past(ep1_in_token); endproperty
  a_ep1_src: assert property (p_ep1_src) else $error("handshake without token");
  property p_brst; bus_reset |=> !address_valid && !hub_configured; endproperty
  a_brst: assert property (p_brst) else $error("bus reset left address or config");
  property p_cfg0; set_config_zero |=> !hub_configured; endproperty
  a_cfg0: assert property (p_cfg0) else $error("config zero left configured");
  property p_rst_se0; $rose(port_resetting[1]) |-> port_drive_se0[1]; endproperty
  a_rst_se0: assert property (p_rst_se0) else $error("reset without se0");
  property p_eop; $fell(port_drive_k[1]) |-> port_drive_se0[1]; endproperty
  a_eop: assert property (p_eop) else $error("resume K not followed by eop");
  property p_eof2;
    port_resetting[1] && !port_drive_se0[1] && eof2 |-> ##[1:2] port_enabled[1] && !port_resetting[1];
  endproperty
  a_eof2: assert property (p_eof2) else $error("reset not finished at eof2");
  c_ack: cover property (ep1_ack);
  c_err: cover property (pslverr);
  c_en: cover property ($rose(port_enabled[1]));
endmodule
bind uhc_port_ctrl uhc_port_ctrl_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_reset(bus_reset),
  .set_config_zero(set_config_zero), .eof2(eof2), .ep1_in_token(ep1_in_token), .ep1_ack(ep1_ack),
  .ep1_nak(ep1_nak), .address_valid(address_valid), .hub_configured(hub_configured),
  .port_enabled(port_enabled), .port_resetting(port_resetting), .port_drive_k(port_drive_k),
  .port_drive_se0(port_drive_se0));
`default_nettype wire

/* verification/uhc_port_ctrl_tb.sv */
// Self-checking bench for the hub port controller over APB.
// Assumes short sequencer counts; pstrb held active, ce dropped once.
`default_nettype none
module uhc_port_ctrl_tb
  import uhc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [UHC_AW-1:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, eof2, ep1_in_token, ep1_ack, ep1_nak;
  logic usb_suspended = 1'h0, upstream_resume = 1'h0, downstream_resume_done = 1'h0;
  logic bus_reset = 1'h0, set_config_zero = 1'h0, tok_go = 1'h0, ce = 1'h1;
  logic address_valid, hub_configured, func_reset, func_suspended;
  logic [7:0] ep1_report;
  logic [UHC_NPORT-1:0] port_enabled, port_suspended, port_resetting, port_drive_k, port_drive_se0, port_forward;
  int fails = 0, samples_checked = 0, cyc = 0, acks = 0, naks = 0, resets_seen = 0;
  always #5 pclk = ~pclk;
  uhc_usb_side_model i_host (.pclk(pclk), .presetn(presetn), .tok_go(tok_go), .eof2(eof2),
    .ep1_in_token(ep1_in_token));
  uhc_port_ctrl #(.RESET_CYC(20), .RESUME_CYC(30), .EOP_CYC(5)) i_dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_suspended(usb_suspended),
    .upstream_resume(upstream_resume), .downstream_resume_done(downstream_resume_done), .bus_reset(bus_reset),
    .set_config_zero(set_config_zero), .eof2(eof2), .ep1_in_token(ep1_in_token), .ep1_ack(ep1_ack),
    .ep1_nak(ep1_nak), .ep1_report(ep1_report), .address_valid(address_valid), .hub_configured(hub_configured),
    .func_reset(func_reset), .func_suspended(func_suspended), .port_enabled(port_enabled),
    .port_suspended(port_suspended), .port_resetting(port_resetting), .port_drive_k(port_drive_k),
    .port_drive_se0(port_drive_se0), .port_forward(port_forward));
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    acks <= acks + (ep1_ack === 1'h1);
    naks <= naks + (ep1_nak === 1'h1);
    resets_seen <= resets_seen + (func_reset === 1'h1);
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [UHC_IW-1:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    // Answer taken at the edge that sees pready high; only the bench timeout ends a hang
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input string n, input logic [UHC_IW-1:0] i, input logic [31:0] x);
    apb(1'h0, i, 8'h0);
    chk(n, x, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic ep1_poll(input logic x);
    int a, k;
    a = acks;
    k = naks;
    @(posedge pclk);
    tok_go <= 1'h1;
    @(posedge pclk);
    tok_go <= 1'h0;
    settle(3);
    chk("ep1_ack", {31'h0, x}, acks - a);
    chk("ep1_nak", {31'h0, !x}, naks - k);
  endtask
  task automatic t_regs();
    rdc("global", UHC_IDX_GLOBAL, 32'h0);
    rdc("power", UHC_IDX_POWER, 32'h0);
    rdc("command", UHC_IDX_CMD, 32'h0);
    apb(1'h1, UHC_IDX_GLOBAL, 8'hff);
    rdc("global", UHC_IDX_GLOBAL, 32'h7);
    chk("addr_cfg", 32'h3, {30'h0, hub_configured, address_valid});
    apb(1'h1, UHC_IDX_CMD, 8'hff);
    rdc("command", UHC_IDX_CMD, 32'h77);
    apb(1'h0, 14'h0001, 8'h0);
    chk("pslverr", 32'h1, {31'h0, e});
  endtask
  task automatic t_flags();
    usb_suspended <= 1'h1;
    settle(2);
    rdc("suspended", UHC_IDX_GLOBAL, 32'h17);
    usb_suspended <= 1'h0;
    upstream_resume <= 1'h1;
    @(posedge pclk);
    upstream_resume <= 1'h0;
    rdc("resume_seen", UHC_IDX_GLOBAL, 32'h0f);
    downstream_resume_done <= 1'h1;
    @(posedge pclk);
    downstream_resume_done <= 1'h0;
    rdc("resume_done", UHC_IDX_GLOBAL, 32'h07);
    set_config_zero <= 1'h1;
    @(posedge pclk);
    set_config_zero <= 1'h0;
    rdc("config_zero", UHC_IDX_GLOBAL, 32'h05);
    bus_reset <= 1'h1;
    @(posedge pclk);
    bus_reset <= 1'h0;
    rdc("bus_reset", UHC_IDX_GLOBAL, 32'h00);
    // Clock enable low must swallow the resume pulse
    ce <= 1'h0;
    upstream_resume <= 1'h1;
    @(posedge pclk);
    upstream_resume <= 1'h0;
    ce <= 1'h1;
    rdc("frozen", UHC_IDX_GLOBAL, 32'h00);
  endtask
  task automatic t_ep1();
    ep1_poll(1'h0);
    apb(1'h1, UHC_IDX_POWER, 8'h02);
    ep1_poll(1'h1);
    chk("report", 32'h1, {31'h0, ep1_report[UHC_BM_HUB]});
    ep1_poll(1'h0);
    apb(1'h1, UHC_IDX_POWER, 8'h00);
    apb(1'h1, UHC_IDX_POWER, 8'hf8);
    ep1_poll(1'h1);
    rdc("power", UHC_IDX_POWER, 32'h08);
    apb(1'h1, UHC_IDX_POWER, 8'h00);
  endtask
  task automatic t_ports();
    apb(1'h1, UHC_IDX_CMD, 8'h12);
    settle(3);
    chk("enable", 32'h1, port_enabled);
    apb(1'h1, UHC_IDX_CMD, 8'h02);
    settle(3);
    chk("disable", 32'h0, port_enabled);
    apb(1'h1, UHC_IDX_CMD, 8'h23);
    settle(3);
    chk("resetting", 32'ha, {port_resetting, port_drive_se0});
    for (int k = 0; k < 200 && port_resetting[1] !== 1'h0; k++) @(negedge pclk);
    chk("reset_end", 32'h2, {port_resetting, port_enabled});
    rdc("change3", UHC_IDX_PCH3, 32'h10);
    ep1_poll(1'h1);
    chk("report3", 32'h8, {24'h0, ep1_report});
    apb(1'h1, UHC_IDX_CMD, 8'h33);
    settle(3);
    chk("suspend", 32'h2, {port_forward[1], port_suspended});
    apb(1'h1, UHC_IDX_CMD, 8'h53);
    apb(1'h1, UHC_IDX_CMD, 8'h44);
    settle(3);
    chk("ignored", 32'h8, {port_suspended, port_drive_k});
    apb(1'h1, UHC_IDX_CMD, 8'h43);
    settle(3);
    chk("drive_k", 32'h2, port_drive_k);
    for (int k = 0; k < 300 && port_suspended[1] !== 1'h0; k++) @(negedge pclk);
    chk("resumed", 32'h2, {port_suspended, port_drive_k, port_enabled});
    rdc("change3", UHC_IDX_PCH3, 32'h14);
    apb(1'h1, UHC_IDX_CMD, 8'h31);
    settle(3);
    chk("func_susp", 32'h1, func_suspended);
    apb(1'h1, UHC_IDX_CMD, 8'h21);
    settle(3);
    chk("func_reset", 32'h1, resets_seen);
    chk("func_wake", 32'h0, func_suspended);
    chk("ports_kept", 32'h2, port_enabled);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_flags();
    t_ep1();
    t_ports();
    complete_run();
  end
endmodule
`default_nettype wire
